//--- hw/flash_clock_security_params.svh
`ifndef FLASH_CLOCK_SECURITY_PARAMS_SVH
`define FLASH_CLOCK_SECURITY_PARAMS_SVH

// Register indices, byte address is four times the index
`define IDX_CLOCK_DIVIDER 4'h0
`define IDX_SECURITY 4'h1
`define IDX_RESERVED_ONE 4'h2
`define IDX_CONFIG 4'h3
`define IDX_TEST_ADDR_LOW 4'h9
`define IDX_TEST_DATA_HIGH 4'ha
`define IDX_TEST_DATA_LOW 4'hb
`define IDX_RESERVED_THREE 4'hc
`define IDX_RESERVED_FOUR 4'hd
`define IDX_RESERVED_FIVE 4'he
`define IDX_LAST 4'hf

// Field positions
`define BIT_LOADED 7
`define BIT_PRESCALE 6
`define BIT_KEY_ACCESS 5
`define KEY_ENABLED 2'b10
`define LOCK_UNSECURED 2'b10

// Timing
`define PRESCALE_RATIO 8
`define PRESCALE_LAST 3'h7
`define MAX_DIVIDE_RATIO 512
`define CONFIG_BYTE_ADDR 16'hff0f

`endif

//--- hw/flash_clock_security_pkg.sv
package flash_clock_security_pkg;

   typedef struct packed {
      logic [1:0] key_enable;
      logic [3:0] user_flags;
      logic [1:0] lock_state;
   } security_fields_t;

   typedef enum logic [2:0] {
      ST_LOAD = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN = 3'b100
   } load_state_t;

   typedef struct packed {
      load_state_t state;
      logic divider_loaded_flag;
      logic prescale_by_eight;
      logic [5:0] divider_value;
      security_fields_t security;
      logic key_write_access;
      logic [2:0] prescale_count;
      logic [5:0] divide_count;
      logic flash_clock_tick;
      logic [31:0] prdata;
   } regs_state_t;

endpackage

//--- hw/flash_clock_security_regs.sv
// Decided for this implementation: the APB slave port.
`include "flash_clock_security_params.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_clock_security_regs
   import flash_clock_security_pkg::*;
#(
   parameter int ADDR_WIDTH = 12
) (
   input wire logic pclk, // APB clock, 125 MHz
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [ADDR_WIDTH-1:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped index, misaligned or out-of-range address
   output logic config_read_req, // Request configuration byte
   output logic [15:0] config_read_addr, // Configuration byte address
   input wire logic config_read_valid, // Configuration byte returned
   input wire logic [7:0] config_read_data, // Configuration byte value
   input wire logic backdoor_unsecure, // Successful backdoor key pulse
   output logic flash_clock_tick, // One-cycle flash clock enable
   output logic backdoor_key_enabled, // Backdoor key access enabled
   output logic part_unsecured, // Part is unsecured
   output logic key_write_access // Key writes gated open
);

   initial begin
      if (ADDR_WIDTH < 6 || ADDR_WIDTH > 32) begin
         $error("ADDR_WIDTH out of range");
      end
   end

   regs_state_t cur;
   regs_state_t next_cur;

   function automatic logic is_mapped(input logic [3:0] idx);
      is_mapped = (idx <= `IDX_CONFIG) || (idx >= `IDX_TEST_ADDR_LOW && idx <= `IDX_RESERVED_FIVE);
   endfunction

   logic [3:0] reg_index;
   logic word_aligned;
   logic in_range;
   logic access;
   logic wr;
   logic rd;
   logic [7:0] divider_word;
   logic [7:0] security_word;
   logic [7:0] config_word;

   assign reg_index = paddr[5:2];
   assign word_aligned = (paddr[1:0] == 2'b00);
   assign in_range = (paddr >> 6) == '0;
   assign access = psel && penable;
   assign wr = access && pwrite && word_aligned && in_range && is_mapped(reg_index);
   // Read is decoded in setup so the data word stands through the access cycle
   assign rd = psel && !penable && !pwrite;

   assign divider_word = {cur.divider_loaded_flag, cur.prescale_by_eight, cur.divider_value};
   assign security_word = cur.security;
   assign config_word = {2'b00, cur.key_write_access, 5'b00000};

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_cur = cur;
      next_cur.flash_clock_tick = 1'b0;
      case (cur.state)
         ST_LOAD: begin
            next_cur.state = ST_WAIT;
         end
         ST_WAIT: begin
            if (config_read_valid) begin
               next_cur.security = config_read_data;
               next_cur.state = ST_RUN;
            end
         end
         ST_RUN: begin
         end
         default: begin
            next_cur.state = ST_LOAD;
         end
      endcase

      // Backdoor unsecure wins over the reset load
      if (backdoor_unsecure) begin
         next_cur.security.lock_state = `LOCK_UNSECURED;
      end

      if (wr && reg_index == `IDX_CLOCK_DIVIDER && !cur.divider_loaded_flag) begin
         next_cur.prescale_by_eight = pwdata[`BIT_PRESCALE];
         next_cur.divider_value = pwdata[5:0];
         next_cur.divider_loaded_flag = 1'b1;
      end
      // Security and reserved registers simply drop writes
      if (wr && reg_index == `IDX_CONFIG) begin
         next_cur.key_write_access = pwdata[`BIT_KEY_ACCESS] &&
            (cur.security.key_enable == `KEY_ENABLED);
      end

      // Divider runs only once loaded; ratio is at most 8 x 64 = 512
      if (cur.divider_loaded_flag) begin
         if (cur.prescale_by_eight && cur.prescale_count != `PRESCALE_LAST) begin
            next_cur.prescale_count = cur.prescale_count + 3'h1;
         end else begin
            next_cur.prescale_count = 3'h0;
            if (cur.divide_count >= cur.divider_value) begin
               next_cur.divide_count = 6'h00;
               next_cur.flash_clock_tick = 1'b1;
            end else begin
               next_cur.divide_count = cur.divide_count + 6'h01;
            end
         end
      end

      next_cur.prdata = 32'h0000_0000;
      if (rd && word_aligned && in_range) begin
         case (reg_index)
            `IDX_CLOCK_DIVIDER: next_cur.prdata = {24'h00_0000, divider_word};
            `IDX_SECURITY: next_cur.prdata = {24'h00_0000, security_word};
            `IDX_CONFIG: next_cur.prdata = {24'h00_0000, config_word};
            default: next_cur.prdata = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // State registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '{state: ST_LOAD, security: 8'h00, default: '0};
      end else begin
         cur <= next_cur;
      end
   end

   // Read data registered at setup, presented during access
   logic pending;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending <= 1'b0;
      end else begin
         pending <= psel && !penable;
      end
   end

   assign pready = pending;
   assign prdata = cur.prdata;
   assign pslverr = access && pending && !(word_aligned && in_range && is_mapped(reg_index));
   assign config_read_req = (cur.state == ST_WAIT);
   assign config_read_addr = `CONFIG_BYTE_ADDR;
   assign flash_clock_tick = cur.flash_clock_tick;
   assign backdoor_key_enabled = (cur.security.key_enable == `KEY_ENABLED);
   assign part_unsecured = (cur.security.lock_state == `LOCK_UNSECURED);
   assign key_write_access = cur.key_write_access;

endmodule // flash_clock_security_regs

`default_nettype wire

//--- dv/flash_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module flash_regs_props #(
   parameter int ADDR_WIDTH = 12
) (
   input wire logic pclk, presetn, psel, penable, pwrite, pready,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic config_read_req, config_read_valid, backdoor_unsecure,
   input wire logic [15:0] config_read_addr,
   input wire logic key_write_access, backdoor_key_enabled, part_unsecured
);
   // ****************
   // Divider write tracker
   // ****************
   logic wrote;
   wire rd = psel && penable && pready && !pwrite;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) wrote <= 1'b0;
      else if (psel && penable && pready && pwrite && paddr == 0) wrote <= 1'b1;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   access_ready_a: assert property (psel && !penable ##1 psel && penable |-> pready)
      else $error("access without ready");
   cfg_addr_a: assert property (config_read_addr == 16'hff0f) else $error("bad byte address");
   cfg_done_a: assert property (config_read_req && config_read_valid |=> !config_read_req)
      else $error("request held after byte");
   unsecure_a: assert property (backdoor_unsecure |-> ##[1:2] part_unsecured)
      else $error("unsecure not forced");
   rsvd_zero_a: assert property (rd && paddr inside {8, 48, 52, 56} |-> prdata == 0)
      else $error("reserved reads nonzero");
   upper_zero_a: assert property (rd |-> prdata[31:8] == 0) else $error("upper bits set");
   loaded_flag_a: assert property (rd && paddr == 0 |-> prdata[7] == wrote)
      else $error("loaded flag wrong");
   key_gate_a: assert property ($rose(key_write_access) |-> $past(backdoor_key_enabled))
      else $error("key access set while disabled");
endmodule // flash_regs_props
bind flash_clock_security_regs flash_regs_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.*);
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cfg_vld = 0, unsec = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [7:0] cfg_byte = 0, b, n;
   logic [15:0] cfg_addr;
   logic pready, pslverr, err, req, tick, key_en, unsecured, key_acc;
   logic [31:0] expq[$];
   int failures = 0, checks_done = 0, c;
   initial forever #4 pclk = ~pclk;
   flash_clock_security_regs u_flash_clock_security_regs (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .config_read_req(req),
      .config_read_addr(cfg_addr), .config_read_valid(cfg_vld), .config_read_data(cfg_byte),
      .backdoor_unsecure(unsec), .flash_clock_tick(tick), .backdoor_key_enabled(key_en),
      .part_unsecured(unsecured), .key_write_access(key_acc));
   // ****************
   // Checking and bus tasks
   // ****************
   task chk(input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      if (failures == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task hang(input logic ok);
      if (!ok) begin
         failures++;
         give_verdict;
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int k;
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge pclk) penable <= 1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
      hang(pready === 1'b1);
      err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      expq.push_back(e);
      apb(0, a, 0);
   endtask
   // Ticks are counted edge to edge, the first gap hides prescaler phase
   task period(output int p);
      int k;
      k = 0;
      do begin @(posedge pclk); k++; end while (tick !== 1'b1 && k < 2000);
      hang(tick === 1'b1);
      p = 0;
      do begin @(posedge pclk); p++; end while (tick !== 1'b1 && p < 2000);
      hang(tick === 1'b1);
   endtask
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
         chk(prdata, expq.pop_front());
      end
   initial begin
      void'($urandom(97895));
      for (int i = 0; i < 4; i++) begin
         presetn <= 0;
         repeat (20) @(posedge pclk);
         presetn <= 1;
         b = {i[1:0], 4'($urandom), 2'(3 - i)};
         n = 8'($urandom % 64);
         c = 0;
         do begin @(posedge pclk); c++; end while (req !== 1'b1 && c < 50);
         hang(req === 1'b1);
         cfg_vld <= 1; cfg_byte <= b;
         @(posedge pclk) cfg_vld <= 0;
         @(posedge pclk);
         chk(key_en, b[7:6] == 2'b10);
         chk(unsecured, b[1:0] == 2'b10);
         rd(0, 0);
         apb(1, 12'h004, ~b); rd(12'h004, b);
         apb(1, 12'h008, 8'hff); rd(12'h008, 0);
         for (int r = 12; r < 15; r++) rd(12'(4 * r), 0);
         apb(1, 12'h00c, 8'h20); rd(12'h00c, {b[7:6] == 2'b10, 5'h0});
         apb(1, 0, {2'b0, n[5:0]} | {i[0], 6'h0});
         rd(0, {2'b10, n[5:0]} | {i[0], 6'h0});
         apb(1, 0, ~n); rd(0, {2'b10, n[5:0]} | {i[0], 6'h0});
         period(c); chk(c, (n + 1) * (i[0] ? 8 : 1));
         apb(1, 12'h100, 8'h01); chk(err, 1);
         unsec <= 1;
         @(posedge pclk) unsec <= 0;
         @(posedge pclk);
         rd(12'h004, {b[7:2], 2'b10});
         chk(unsecured, 1);
      end
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
